/* File: src/pmw_regs.svh */
// register map, field positions, reset values and timing figures of the wake-up sequencer
// assumes a 100 MHz system clock and a 32-bit axi4-lite register bus
`ifndef PMW_REGS_SVH
`define PMW_REGS_SVH
// register byte addresses
`define PMW_OSC_ADDR 8'h00
`define PMW_IRQ_ADDR 8'h04
`define PMW_CFG_ADDR 8'h08
`define PMW_STAT_ADDR 8'h0C
// oscillator control fields
`define PMW_OSC_RST 8'h00
`define PMW_OSC_WMASK 8'hF3
`define PMW_IDLE_BIT 7
`define PMW_FSEL_HI 6
`define PMW_FSEL_LO 4
`define PMW_PRDY_BIT 3
`define PMW_ISTB_BIT 2
`define PMW_CSEL_HI 1
`define PMW_CSEL_LO 0
// interrupt control and configuration fields
`define PMW_GIRQ_BIT 7
`define PMW_PRI_HI 2
`define PMW_PRI_LO 0
`define PMW_DUAL_BIT 3
`define PMW_FAIL_BIT 4
`define PMW_CFG_RST 5'h00
// bus answers
`define PMW_RESP_OK 2'h0
`define PMW_RESP_ERR 2'h2
// timing
`define PMW_CLK_NS 10
`define PMW_EXIT_DLY_NS 10000
`define PMW_STARTUP_TICKS 1024
`define PMW_PLL_LOCK_NS 2000000
`define PMW_FAST_INTERNAL_OSC_STAB_NS 1000000
`endif

/* File: src/pmw_pkg.sv */
// types used by the wake-up sequencer
// assumes the constants of pmw_regs.svh
package pmw_pkg;
    // primary clock kind, order matches the configuration field
    typedef enum logic [2:0] {PMW_XTAL_LOW, PMW_XTAL_STD, PMW_XTAL_FAST, PMW_XTAL_PLL,
        PMW_EXT_CLK, PMW_RES_CAP, PMW_INT_OSC} pmw_pri_t;
    // power-managed modes
    typedef enum logic [2:0] {PMW_PM_PRIM_RUN, PMW_PM_SEC_RUN, PMW_PM_INT_RUN, PMW_PM_PRIM_IDLE,
        PMW_PM_SEC_IDLE, PMW_PM_INT_IDLE, PMW_PM_SLEEP} pmw_pm_t;
    // sequencer states
    typedef enum logic [1:0] {PMW_SQ_RESET, PMW_SQ_ACTIVE, PMW_SQ_LOW, PMW_SQ_WAKE} pmw_seq_t;
    // system clock multiplexer select
    typedef enum logic [1:0] {PMW_CLK_PRIM, PMW_CLK_SEC, PMW_CLK_INT} pmw_clk_t;
endpackage : pmw_pkg

/* File: src/pmw_wake_ctrl.sv */
// wake-up sequencer for power-managed modes with an axi4-lite register slave
// assumes interrupt flags, watchdog and cpu strobes are on clk; reset source and oscillator input are pins
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "pmw_regs.svh"
module pmw_wake_ctrl #(
    parameter int NUM_IRQ = 8,
    parameter int PLL_LOCK_CYC = `PMW_PLL_LOCK_NS / `PMW_CLK_NS,
    parameter int STAB_CYC = `PMW_FAST_INTERNAL_OSC_STAB_NS / `PMW_CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt sources
    input wire logic [NUM_IRQ-1:0] irq_flags,
    input wire logic [NUM_IRQ-1:0] irq_enables,
    // reset source pin and primary oscillator input pin
    input wire logic reset_src_pin,
    input wire logic osc_tick_pin,
    // watchdog and cpu strobes
    input wire logic watchdog_timeout,
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic clock_fail,
    // cpu core and clock multiplexer
    output logic cpu_clock_en,
    output logic cpu_reset,
    output logic irq_vector,
    output logic [1:0] sys_clock_sel,
    output logic primary_osc_en,
    output logic watchdog_clear,
    output logic watchdog_reset
);

    // exit delay, longest figure rounded down
    localparam int EXIT_CYC = `PMW_EXIT_DLY_NS / `PMW_CLK_NS;
    localparam int CW = 18;

    // sequencer state
    pmw_pkg::pmw_seq_t seq_reg;
    pmw_pkg::pmw_pm_t mode_reg;
    pmw_pkg::pmw_clk_t clk_sel_reg;
    logic cpu_clk_reg;
    logic cpu_rst_reg;
    logic prim_en_reg;
    logic vec_pend_reg; // branch owed at resume
    logic vec_reg;
    // registers and flags
    logic [7:0] osc_ctl_reg;
    logic global_irq_enable_reg;
    logic [4:0] cfg_reg;
    logic prdy_reg; // primary clock ready flag
    logic int_stable_reg; // internal oscillator stable flag
    // counters
    logic [9:0] exit_cnt_reg;
    logic [10:0] startup_cnt_reg;
    logic [CW-1:0] pll_cnt_reg;
    logic [CW-1:0] stab_cnt_reg;
    logic prim_rdy_reg;
    // synchronisers and edges
    logic rsrc_s1_reg, rsrc_s2_reg;
    logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
    logic pend_d_reg;
    // watchdog outputs
    logic wd_clr_reg;
    logic wd_rst_reg;
    // bus slave
    logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // mode halts the cpu
    function automatic logic pm_halted(input pmw_pkg::pmw_pm_t m);
        return m inside {pmw_pkg::PMW_PM_PRIM_IDLE, pmw_pkg::PMW_PM_SEC_IDLE,
            pmw_pkg::PMW_PM_INT_IDLE, pmw_pkg::PMW_PM_SLEEP};
    endfunction : pm_halted

    // clock that feeds a mode
    function automatic pmw_pkg::pmw_clk_t pm_clock(input pmw_pkg::pmw_pm_t m);
        if (m inside {pmw_pkg::PMW_PM_SEC_RUN, pmw_pkg::PMW_PM_SEC_IDLE})
            return pmw_pkg::PMW_CLK_SEC;
        if (m inside {pmw_pkg::PMW_PM_INT_RUN, pmw_pkg::PMW_PM_INT_IDLE})
            return pmw_pkg::PMW_CLK_INT;
        return pmw_pkg::PMW_CLK_PRIM;
    endfunction : pm_clock

    // crystal primaries need the start-up timer
    function automatic logic is_xtal(input pmw_pkg::pmw_pri_t p);
        return p inside {pmw_pkg::PMW_XTAL_LOW, pmw_pkg::PMW_XTAL_STD,
            pmw_pkg::PMW_XTAL_FAST, pmw_pkg::PMW_XTAL_PLL};
    endfunction : is_xtal

    // decoded conditions
    pmw_pkg::pmw_pri_t pri;
    pmw_pkg::pmw_pm_t entry_mode;
    logic [2:0] fsel;
    logic irq_rise, cpu_run, wd_rst_ev, dev_rst, wake_ev, fast_start, exit_done;
    logic osc_edge, no_delay, int_in_use, wr_go, wr_en, rd_go, rd_en, osc_wr, enter;
    assign pri = pmw_pkg::pmw_pri_t'(cfg_reg[`PMW_PRI_HI:`PMW_PRI_LO]);
    assign fsel = osc_ctl_reg[`PMW_FSEL_HI:`PMW_FSEL_LO];
    assign irq_rise = (|(irq_flags & irq_enables)) & ~pend_d_reg;
    assign cpu_run = cpu_clk_reg & ~cpu_rst_reg;
    assign wd_rst_ev = watchdog_timeout & cpu_run;
    assign dev_rst = rsrc_s2_reg | wd_rst_ev;
    assign wake_ev = (seq_reg == pmw_pkg::PMW_SQ_LOW) & (irq_rise | (watchdog_timeout & pm_halted(mode_reg)));
    assign fast_start = cfg_reg[`PMW_DUAL_BIT] | cfg_reg[`PMW_FAIL_BIT];
    assign exit_done = exit_cnt_reg == 10'h000;
    assign osc_edge = osc_s2_reg & ~osc_s3_reg;
    // internal primary woken from an internal mode already runs stable
    assign no_delay = (pm_clock(mode_reg) == pmw_pkg::PMW_CLK_INT) & (pri == pmw_pkg::PMW_INT_OSC)
        & (fsel != 3'h0);
    assign int_in_use = (clk_sel_reg == pmw_pkg::PMW_CLK_INT) | (pri == pmw_pkg::PMW_INT_OSC);
    assign enter = sleep_instr & cpu_run & ~wake_ev;
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
    assign wr_en = awready_reg & s_axi_awvalid & s_axi_wvalid;
    assign rd_go = s_axi_arvalid & ~arready_reg & ~rvalid_reg;
    assign rd_en = arready_reg & s_axi_arvalid;
    assign osc_wr = wr_en & (s_axi_awaddr == `PMW_OSC_ADDR) & s_axi_wstrb[0];

    // mode selected by the sleep instruction
    always_comb
    begin
        if (!osc_ctl_reg[`PMW_IDLE_BIT])
            entry_mode = osc_ctl_reg[`PMW_CSEL_HI] ? pmw_pkg::PMW_PM_INT_RUN :
                osc_ctl_reg[`PMW_CSEL_LO] ? pmw_pkg::PMW_PM_SEC_RUN : pmw_pkg::PMW_PM_SLEEP;
        else
            entry_mode = osc_ctl_reg[`PMW_CSEL_HI] ? pmw_pkg::PMW_PM_INT_IDLE :
                osc_ctl_reg[`PMW_CSEL_LO] ? pmw_pkg::PMW_PM_SEC_IDLE : pmw_pkg::PMW_PM_PRIM_IDLE;
    end

    // pin synchronisers and interrupt edge memory
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rsrc_s1_reg <= 1'b0;
            rsrc_s2_reg <= 1'b0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            pend_d_reg <= 1'b0;
        end
        else
        begin
            rsrc_s1_reg <= reset_src_pin;
            rsrc_s2_reg <= rsrc_s1_reg;
            osc_s1_reg <= osc_tick_pin;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            pend_d_reg <= |(irq_flags & irq_enables);
        end
    end

    // fixed exit delay, runs alongside the primary start-up
    always_ff @(posedge clk)
    begin
        if (!rst_n || dev_rst)
            exit_cnt_reg <= 10'h000;
        else if (wake_ev)
            exit_cnt_reg <= (pm_halted(mode_reg) && !no_delay) ? 10'(EXIT_CYC) : 10'h000;
        else if (!exit_done)
            exit_cnt_reg <= exit_cnt_reg - 10'h001;
    end

    // primary readiness: start-up timer for crystals, then pll lock for the pll crystal only
    always_ff @(posedge clk)
    begin
        if (!rst_n || !prim_en_reg)
        begin
            startup_cnt_reg <= 11'h000;
            pll_cnt_reg <= '0;
            prim_rdy_reg <= 1'b0;
        end
        else if (!is_xtal(pri))
            prim_rdy_reg <= 1'b1;
        else if (startup_cnt_reg != 11'(`PMW_STARTUP_TICKS))
            startup_cnt_reg <= startup_cnt_reg + {10'h000, osc_edge};
        else if (pri == pmw_pkg::PMW_XTAL_PLL && pll_cnt_reg != CW'(PLL_LOCK_CYC))
            pll_cnt_reg <= pll_cnt_reg + 1'b1;
        else
            prim_rdy_reg <= 1'b1;
    end

    // internal oscillator stabilisation and its flag
    always_ff @(posedge clk)
    begin
        if (!rst_n || dev_rst || fsel == 3'h0 || !int_in_use)
        begin
            stab_cnt_reg <= '0;
            int_stable_reg <= 1'b0;
        end
        else if (stab_cnt_reg != CW'(STAB_CYC))
            stab_cnt_reg <= stab_cnt_reg + 1'b1;
        else
            int_stable_reg <= 1'b1;
    end

    // wake-up sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n || dev_rst)
        begin
            // reset wins over any wake request
            seq_reg <= pmw_pkg::PMW_SQ_RESET;
            mode_reg <= pmw_pkg::PMW_PM_PRIM_RUN;
            clk_sel_reg <= pmw_pkg::PMW_CLK_PRIM;
            cpu_clk_reg <= 1'b0;
            cpu_rst_reg <= 1'b1;
            prim_en_reg <= 1'b1;
            prdy_reg <= 1'b0;
            vec_pend_reg <= 1'b0;
            vec_reg <= 1'b0;
        end
        else if (enter)
        begin
            // sleep instruction: primary stops unless primary idle
            vec_reg <= 1'b0;
            seq_reg <= pmw_pkg::PMW_SQ_LOW;
            mode_reg <= entry_mode;
            clk_sel_reg <= pm_clock(entry_mode);
            cpu_clk_reg <= !pm_halted(entry_mode);
            prim_en_reg <= entry_mode == pmw_pkg::PMW_PM_PRIM_IDLE;
            if (entry_mode != pmw_pkg::PMW_PM_PRIM_IDLE)
                prdy_reg <= 1'b0;
        end
        else
        begin
            vec_reg <= 1'b0;
            unique case (seq_reg)
                pmw_pkg::PMW_SQ_RESET:
                begin
                    if (rsrc_s2_reg)
                        cpu_rst_reg <= 1'b1;
                    else if (prim_rdy_reg)
                    begin
                        // held until primary ready, then flag and run
                        prdy_reg <= 1'b1;
                        cpu_rst_reg <= 1'b0;
                        cpu_clk_reg <= 1'b1;
                        seq_reg <= pmw_pkg::PMW_SQ_ACTIVE;
                    end
                    else if (fast_start)
                    begin
                        // run early from the internal block
                        cpu_rst_reg <= 1'b0;
                        cpu_clk_reg <= 1'b1;
                        clk_sel_reg <= pmw_pkg::PMW_CLK_INT;
                        mode_reg <= pmw_pkg::PMW_PM_INT_RUN;
                        seq_reg <= pmw_pkg::PMW_SQ_WAKE;
                    end
                end
                pmw_pkg::PMW_SQ_ACTIVE:
                    seq_reg <= pmw_pkg::PMW_SQ_ACTIVE;
                pmw_pkg::PMW_SQ_LOW:
                begin
                    if (wake_ev)
                    begin
                        seq_reg <= pmw_pkg::PMW_SQ_WAKE;
                        prim_en_reg <= 1'b1;
                        vec_pend_reg <= irq_rise & global_irq_enable_reg;
                        if (pm_halted(mode_reg))
                            cpu_clk_reg <= 1'b0;
                        if (mode_reg == pmw_pkg::PMW_PM_SLEEP && cfg_reg[`PMW_DUAL_BIT])
                            clk_sel_reg <= pmw_pkg::PMW_CLK_INT;
                    end
                end
                pmw_pkg::PMW_SQ_WAKE:
                begin
                    // execute on the mode clock once the exit delay is over; from sleep on the internal clock with the dual bit set, else once the primary is ready
                    if (exit_done && (mode_reg != pmw_pkg::PMW_PM_SLEEP || cfg_reg[`PMW_DUAL_BIT]))
                        cpu_clk_reg <= 1'b1;
                    if (exit_done && vec_pend_reg && (cpu_clk_reg || prim_rdy_reg
                        || mode_reg != pmw_pkg::PMW_PM_SLEEP || cfg_reg[`PMW_DUAL_BIT]))
                    begin
                        vec_reg <= 1'b1;
                        vec_pend_reg <= 1'b0;
                    end
                    if (exit_done && prim_rdy_reg)
                    begin
                        // switch back to the primary clock
                        seq_reg <= pmw_pkg::PMW_SQ_ACTIVE;
                        mode_reg <= pmw_pkg::PMW_PM_PRIM_RUN;
                        clk_sel_reg <= pmw_pkg::PMW_CLK_PRIM;
                        cpu_clk_reg <= 1'b1;
                        prdy_reg <= is_xtal(pri) | prdy_reg;
                    end
                end
            endcase
        end
    end

    // software registers; device resets clear oscillator control
    always_ff @(posedge clk)
    begin
        if (!rst_n || dev_rst)
        begin
            osc_ctl_reg <= `PMW_OSC_RST;
            global_irq_enable_reg <= 1'b0;
        end
        else if (wr_en && s_axi_wstrb[0])
        begin
            if (osc_wr)
                osc_ctl_reg <= s_axi_wdata[7:0] & `PMW_OSC_WMASK;
            if (s_axi_awaddr == `PMW_IRQ_ADDR)
                global_irq_enable_reg <= s_axi_wdata[`PMW_GIRQ_BIT];
        end
    end

    // configuration survives device resets
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg_reg <= `PMW_CFG_RST;
        else if (wr_en && s_axi_wstrb[0] && s_axi_awaddr == `PMW_CFG_ADDR)
            cfg_reg <= s_axi_wdata[4:0];
    end

    // watchdog clear and reset strobes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wd_clr_reg <= 1'b0;
            wd_rst_reg <= 1'b0;
        end
        else
        begin
            wd_clr_reg <= sleep_instr | watchdog_clear_instr | (clock_fail & cfg_reg[`PMW_FAIL_BIT])
                | (osc_wr & int_in_use & (s_axi_wdata[`PMW_FSEL_HI:`PMW_FSEL_LO] != fsel));
            wd_rst_reg <= wd_rst_ev;
        end
    end

    // axi4-lite write: address and data taken together
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `PMW_RESP_OK;
        end
        else
        begin
            awready_reg <= wr_go;
            if (wr_en)
            begin
                bvalid_reg <= 1'b1;
                // unmapped address answers slave error
                bresp_reg <= (s_axi_awaddr inside {`PMW_OSC_ADDR, `PMW_IRQ_ADDR, `PMW_CFG_ADDR,
                    `PMW_STAT_ADDR}) ? `PMW_RESP_OK : `PMW_RESP_ERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // axi4-lite read with register mux
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `PMW_RESP_OK;
        end
        else
        begin
            arready_reg <= rd_go;
            if (rd_en)
            begin
                rvalid_reg <= 1'b1;
                rresp_reg <= `PMW_RESP_OK;
                unique case (s_axi_araddr)
                    `PMW_OSC_ADDR: rdata_reg <= {24'h00_0000, osc_ctl_reg[7:4], prdy_reg,
                        int_stable_reg, osc_ctl_reg[1:0]};
                    `PMW_IRQ_ADDR: rdata_reg <= {24'h00_0000, global_irq_enable_reg, 7'h00};
                    `PMW_CFG_ADDR: rdata_reg <= {27'h000_0000, cfg_reg};
                    `PMW_STAT_ADDR: rdata_reg <= {24'h00_0000, 1'b0, prim_rdy_reg, seq_reg, 1'b0, mode_reg};
                    default:
                    begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= `PMW_RESP_ERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = awready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign cpu_clock_en = cpu_clk_reg;
    assign cpu_reset = cpu_rst_reg;
    assign irq_vector = vec_reg;
    assign sys_clock_sel = clk_sel_reg;
    assign primary_osc_en = prim_en_reg;
    assign watchdog_clear = wd_clr_reg;
    assign watchdog_reset = wd_rst_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_irq_wake;
        seq_reg == pmw_pkg::PMW_SQ_LOW && irq_rise && !dev_rst;
    endsequence
    sequence s_halt_wake;
        wake_ev && !dev_rst && pm_halted(mode_reg) && !no_delay;
    endsequence
    a_irq_wake: assert property (s_irq_wake |=> seq_reg == pmw_pkg::PMW_SQ_WAKE)
        else $error("enabled interrupt did not start wake");
    a_no_branch: assert property (s_irq_wake ##0 !global_irq_enable_reg |=> !vec_pend_reg)
        else $error("branch owed without global enable");
    a_exit_len: assert property (s_halt_wake |=> exit_cnt_reg == 10'(EXIT_CYC))
        else $error("exit delay not loaded");
    a_exit_resume: assert property (seq_reg == pmw_pkg::PMW_SQ_WAKE && $rose(cpu_clk_reg)
        |-> $past(exit_cnt_reg) == 10'h000)
        else $error("cpu resumed inside exit delay");
    a_wd_wake: assert property (seq_reg == pmw_pkg::PMW_SQ_LOW && pm_halted(mode_reg)
        && watchdog_timeout && !rsrc_s2_reg |=> !cpu_rst_reg && seq_reg == pmw_pkg::PMW_SQ_WAKE)
        else $error("watchdog while halted did not wake");
    a_wd_reset: assert property (wd_rst_ev |=> cpu_rst_reg && wd_rst_reg)
        else $error("watchdog while running did not reset");
    a_osc_clear: assert property (dev_rst |=> osc_ctl_reg == `PMW_OSC_RST)
        else $error("oscillator control kept after reset");
    a_wd_clear: assert property (sleep_instr || watchdog_clear_instr |=> wd_clr_reg)
        else $error("watchdog not cleared");
    a_startup_cnt: assert property ($rose(prim_rdy_reg) && is_xtal(pri)
        |-> startup_cnt_reg == 11'(`PMW_STARTUP_TICKS))
        else $error("crystal ready before start-up count");
    a_reset_hold: assert property (seq_reg == pmw_pkg::PMW_SQ_RESET && !prim_rdy_reg && !fast_start
        |=> cpu_rst_reg)
        else $error("reset released before primary ready");
    a_switch_back: assert property (seq_reg == pmw_pkg::PMW_SQ_WAKE && exit_done && prim_rdy_reg
        && !dev_rst && !enter |=> seq_reg == pmw_pkg::PMW_SQ_ACTIVE && clk_sel_reg == pmw_pkg::PMW_CLK_PRIM)
        else $error("switch back to primary missing");

endmodule : pmw_wake_ctrl

/* File: bench/pmw_far_model.sv */
// far-side model: the primary crystal oscillator feeding the start-up timer
// assumes the sequencer synchronises the oscillator pin on its own
`timescale 1ns/1ps
module pmw_far_model #(
    parameter real HALF_NS = 23.0
) (
    // oscillator enable from the sequencer
    input logic osc_en,
    // oscillator pin
    output logic osc_tick_pin
);
    // crystal swings only while enabled, phase unrelated to clk
    initial
    begin
        osc_tick_pin = 1'b0;
        forever
        begin
            #(HALF_NS);
            osc_tick_pin = (osc_en === 1'b1) ? ~osc_tick_pin : 1'b0;
        end
    end
endmodule : pmw_far_model

/* File: bench/testbench.sv */
// self-checking bench for the wake-up sequencer
// assumes pmw_far_model as the primary oscillator
`timescale 1ns/1ps
`include "pmw_regs.svh"
module testbench;
    // bench drives
    logic clk, rst_n, awv, wv, bre, arv, rre, slp, wdt, clr, rpin, cfl;
    logic [7:0] awa, ara, fl, en;
    logic [31:0] wd, rd, got;
    // design outputs
    logic awr, wr, bv, arr, rv, cen, crst, vec, posc, wclr, wrst, tick;
    logic [1:0] br, rr, csel, rsp;
    int mismatches, n_compared, n;
    // short pll and stabilisation counts keep the run brief
    pmw_wake_ctrl #(.NUM_IRQ(8), .PLL_LOCK_CYC(20), .STAB_CYC(10)) i_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .irq_flags(fl), .irq_enables(en), .reset_src_pin(rpin),
        .osc_tick_pin(tick), .watchdog_timeout(wdt), .sleep_instr(slp), .watchdog_clear_instr(clr),
        .clock_fail(cfl), .cpu_clock_en(cen), .cpu_reset(crst), .irq_vector(vec), .sys_clock_sel(csel),
        .primary_osc_en(posc), .watchdog_clear(wclr), .watchdog_reset(wrst));
    pmw_far_model i_far (.osc_en(posc), .osc_tick_pin(tick));
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // verdict and end of run
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // one comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // axi4-lite write, address and data offered together
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
        do @(posedge clk); while (awr !== 1'b1 || wr !== 1'b1);
        {awv, wv} <= 2'b00;
        do @(posedge clk); while (bv !== 1'b1);
        r = br;
    endtask : wr_reg
    // axi4-lite read
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        {ara, arv, rre} <= {a, 2'b11};
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rd;
        r = rr;
    endtask : rd_reg
    // wait, bounded, until the cpu leaves reset
    task automatic wait_run();
        for (n = 0; crst !== 1'b0 && n < 20000; n++)
            @(posedge clk);
    endtask : wait_run
    // hang guard
    initial
    begin
        // about three times the expected run of some 13000 cycles
        #400_000;
        mismatches++;
        complete_run();
    end
    // main sequence
    initial
    begin
        {rst_n, awv, wv, bre, arv, rre, slp, wdt, clr, rpin, cfl} = '0;
        {awa, ara, fl, en, wd} = '0;
        mismatches = 0;
        n_compared = 0;
        n = $urandom(32'hd53f);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("cpu_reset", 1, crst);
        rd_reg(`PMW_OSC_ADDR, got, rsp);
        chk("osc_reset", 0, got);
        wait_run();
        rd_reg(`PMW_OSC_ADDR, got, rsp);
        chk("ready_flag", 1, got[`PMW_PRDY_BIT]);
        rd_reg(8'h10, got, rsp);
        chk("unmapped", `PMW_RESP_ERR, rsp);
        wr_reg(`PMW_CFG_ADDR, 32'h0000_0005, rsp);
        chk("wr_resp", `PMW_RESP_OK, rsp);
        // two interrupt wakes (vector on, off) then a watchdog wake, all from sleep
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(`PMW_IRQ_ADDR, ($urandom() & 32'h0000_007f) | (i == 0 ? 32'h0000_0080 : 32'h0), rsp);
            slp <= 1'b1;
            @(posedge clk);
            {slp, fl} <= {1'b0, 8'h01 << $urandom_range(7)};
            @(posedge clk);
            chk("sleep_wdt_clear", 1, wclr);
            repeat (20) @(posedge clk);
            chk("halted", 0, cen);
            chk("primary_off", 0, posc);
            if (i == 2)
                wdt <= 1'b1;
            else
                en <= fl;
            for (n = 0; cen !== 1'b1 && n < 3000; n++)
            begin
                @(posedge clk);
                wdt <= 1'b0;
            end
            chk("exit_delay", 1, n >= 1000 && n <= 1010);
            chk("vector", i == 0, vec);
            chk("no_wdt_reset", 0, wrst);
            {fl, en} <= '0;
        end
        // software raises the internal frequency, then a watchdog expiry while running resets
        wr_reg(`PMW_OSC_ADDR, 32'h0000_0070, rsp);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        @(posedge clk);
        chk("wdt_reset", 1, wrst);
        chk("wdt_cpu_reset", 1, crst);
        wait_run();
        rd_reg(`PMW_OSC_ADDR, got, rsp);
        chk("osc_after_wdt", 32'h0000_0008, got);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        chk("instr_wdt_clear", 1, wclr);
        // crystal primary with fast start: clock loss, sleep, pin reset, early run, switch back
        wr_reg(`PMW_CFG_ADDR, 32'h0000_0019, rsp);
        cfl <= 1'b1;
        @(posedge clk);
        cfl <= 1'b0;
        @(posedge clk);
        chk("fail_wdt_clear", 1, wclr);
        slp <= 1'b1;
        @(posedge clk);
        {slp, rpin} <= 2'b01;
        repeat (6) @(posedge clk);
        rpin <= 1'b0;
        wait_run();
        chk("fast_start_run", 0, crst);
        chk("fast_start_clock", 2, csel);
        for (n = 0; csel !== 2'h0 && n < 20000; n++)
            @(posedge clk);
        rd_reg(`PMW_OSC_ADDR, got, rsp);
        chk("switch_back", 32'h0000_0008, got);
        complete_run();
    end
endmodule : testbench
